// *** bench/cfg_host.sv ***
// Host model that drives the register port of the output channel bank.
`timescale 1ns/100ps
module cfg_host
(
  input  wire logic                  mclk_i,
  input  wire logic [15:0]           rdata_i,
  input  wire logic                  rvalid_i,
  output outbank_pkg::reg_req_t      req_o
);
  // The port stays idle until the bench asks for a transfer.
  initial req_o = '0;

  // Writable bits per index; unmapped indices get all ones to probe refusal.
  function automatic logic [15:0] field_mask(input logic [3:0] a);
    case (a)
      outbank_pkg::OFS_PAIR_AB_CTRL, outbank_pkg::OFS_PAIR_CD_CTRL: return 16'h01ff;
      outbank_pkg::OFS_PAIR_AB_DIV, outbank_pkg::OFS_PAIR_CD_DIV:   return 16'h00ff;
      default: return 16'hffff;
    endcase
  endfunction

  // One-cycle write strobe; reserved bits of mapped registers always leave as zero.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    req_o <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d & field_mask(a)};
    @(posedge mclk_i);
    req_o <= '0;
  endtask

  // One-cycle read strobe; the answer stands for one cycle after the taking edge.
  task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic v);
    @(posedge mclk_i);
    req_o <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk_i);
    req_o <= '0;
    @(negedge mclk_i);
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule

// *** bench/tb.sv ***
// Self-checking testbench for the output channel configuration bank.
`timescale 1ns/100ps
module tb;
  logic                   mclk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  logic                   sync_rel = 1'b0;
  logic                   run = 1'b1;
  outbank_pkg::reg_req_t  req;
  outbank_pkg::chan_out_t ch_a, ch_b, ch_c, ch_d;
  logic                   sup_ab, sup_cd, rvalid;
  logic [15:0]            rdata, d;
  logic                   v;
  int                     bad_count = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  int                     p, diffs, highs;

  // ****************************************************************
  // Clock, design and host.
  // ****************************************************************
  always #20 mclk_i = ~mclk_i;

  output_channel_config_bank u_output_channel_config_bank
  (
    .mclk_i                  (mclk_i),
    .rst_n_i                 (rst_n_i),
    .req_i                   (req),
    .divider_sync_release_i  (sync_rel),
    .device_run_not_held_i   (run),
    .chan_a_o                (ch_a),
    .chan_b_o                (ch_b),
    .chan_c_o                (ch_c),
    .chan_d_o                (ch_d),
    .pair_ab_supply_select_o (sup_ab),
    .pair_cd_supply_select_o (sup_cd),
    .rdata_o                 (rdata),
    .rvalid_o                (rvalid)
  );

  cfg_host u_cfg_host
  (
    .mclk_i   (mclk_i),
    .rdata_i  (rdata),
    .rvalid_i (rvalid),
    .req_o    (req)
  );

  // ****************************************************************
  // Checking helpers.
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reads a register and compares both the valid pulse and the data.
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    u_cfg_host.rd(a, d, v);
    check("rvalid", {15'h0000, v}, 16'h0001);
    check("rdata", d, exp);
  endtask

  // Cycles between two rising edges of the chosen divided clock.
  task automatic measure(input logic sel, output int per);
    int n, first, hits;
    logic prv, cur;
    n = 0;
    hits = 0;
    first = 0;
    prv = 1'b1;
    per = 0;
    while (hits < 2 && n < 2000)
    begin
      @(posedge mclk_i);
      n++;
      cur = sel ? ch_c.clk_out : ch_a.clk_out;
      if (cur === 1'b1 && prv === 1'b0)
      begin
        hits++;
        if (hits == 1)
          first = n;
        else
          per = n - first;
      end
      prv = cur;
    end
  endtask

  // Hung runs end as a failure; the longest path is far below this ceiling.
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // Reset contents and an unmapped read.
    for (int i = 0; i < 5; i++)
      rd_chk((i == 4) ? 4'h3 : 4'(i + 5), 16'h0000);
    // Full-width writes keep only the documented fields; unmapped writes vanish.
    u_cfg_host.wr(4'h5, 16'hffff);
    u_cfg_host.wr(4'h8, 16'hffff);
    u_cfg_host.wr(4'h3, 16'hffff);
    rd_chk(4'h5, 16'h01ff);
    rd_chk(4'h8, 16'h00ff);
    rd_chk(4'h3, 16'h0000);
    // Every state and driver code on every channel; dividers held, so run reads low.
    for (int s = 0; s < 4; s++)
      for (int t = 0; t < 4; t++)
      begin
        d = {7'h00, 2'(3 - t), 2'(3 - s), 2'(t), 2'(s), 1'(s)};
        u_cfg_host.wr(4'h5, d);
        u_cfg_host.wr(4'h7, d);
        repeat (3) @(posedge mclk_i);
        check("chan_a", {12'h000, ch_a}, {12'h000, s == 3, s != 0, 2'(t)});
        check("chan_b", {12'h000, ch_b}, {12'h000, s == 0, s != 3, 2'(3 - t)});
        check("chan_c", {12'h000, ch_c}, {12'h000, s == 3, s != 0, 2'(t)});
        check("chan_d", {12'h000, ch_d}, {12'h000, s == 0, s != 3, 2'(3 - t)});
        check("supply", {14'h0000, sup_ab, sup_cd}, {14'h0000, 1'(s), 1'(s)});
      end
    // Device hold silences the channel outputs but keeps the register contents.
    @(posedge mclk_i);
    run <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("held_en", {12'h000, ch_a.drive_en, ch_b.drive_en, ch_c.drive_en, ch_d.drive_en}, 16'h0000);
    // The last loop pass left static high on both lower channels and supply bit set.
    rd_chk(4'h5, 16'h001f);
    @(posedge mclk_i);
    run <= 1'b1;
    // Divider ratios, including the boundary values 0 and 255.
    u_cfg_host.wr(4'h6, 16'h0000);
    u_cfg_host.wr(4'h8, 16'h0004);
    u_cfg_host.wr(4'h5, 16'h0022);
    u_cfg_host.wr(4'h7, 16'h0022);
    sync_rel <= 1'b1;
    measure(1'b0, p);
    check("period_ab", p[15:0], 16'h0002);
    measure(1'b1, p);
    check("period_cd", p[15:0], 16'h000a);
    u_cfg_host.wr(4'h6, 16'h00ff);
    measure(1'b0, p);
    measure(1'b0, p);
    check("period_max", p[15:0], 16'h0200);
    // Sync hold keeps clocks low; release starts both pairs together.
    sync_rel <= 1'b0;
    u_cfg_host.wr(4'h6, 16'h0002);
    u_cfg_host.wr(4'h8, 16'h0002);
    highs = 0;
    repeat (20)
    begin
      @(posedge mclk_i);
      highs += int'(ch_a.clk_out === 1'b1) + int'(ch_c.clk_out === 1'b1);
    end
    check("held_high", highs[15:0], 16'h0000);
    sync_rel <= 1'b1;
    diffs = 0;
    repeat (40)
    begin
      @(posedge mclk_i);
      diffs += int'(ch_a.clk_out !== ch_c.clk_out);
      highs += int'(ch_a.clk_out === 1'b1);
    end
    check("aligned", diffs[15:0], 16'h0000);
    check("running", {15'h0000, highs != 0}, 16'h0001);
    end_of_test();
  end
endmodule

// *** hdl/outbank_pkg.sv ***
// Package of offsets, field positions, reset values and carrier types for the output channel bank.
package outbank_pkg;

  // ****************************************************************
  // Register offsets (word index on the configuration port).
  // ****************************************************************
  localparam logic [3:0] OFS_PAIR_AB_CTRL = 4'h5;
  localparam logic [3:0] OFS_PAIR_AB_DIV  = 4'h6;
  localparam logic [3:0] OFS_PAIR_CD_CTRL = 4'h7;
  localparam logic [3:0] OFS_PAIR_CD_DIV  = 4'h8;

  // ****************************************************************
  // Field positions inside a pair control register, and the register widths.
  // ****************************************************************
  localparam int POS_SUPPLY   = 0;
  localparam int POS_LO_STATE = 1;
  localparam int POS_LO_DRV   = 3;
  localparam int POS_HI_STATE = 5;
  localparam int POS_HI_DRV   = 7;
  localparam int CTRL_BITS    = 9;
  localparam int DIV_BITS     = 8;

  // ****************************************************************
  // Reset values of the stored fields.
  // ****************************************************************
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [7:0] DIV_RESET  = 8'h00;

  // Output state codes.
  typedef enum logic [1:0]
  {
    ST_OFF  = 2'h0,
    ST_RUN  = 2'h1,
    ST_LOW  = 2'h2,
    ST_HIGH = 2'h3
  } out_state_t;

  // Driver type codes; both low codes mean the low-voltage differential driver.
  typedef enum logic [1:0]
  {
    DRV_LVDS  = 2'h0,
    DRV_LVDS2 = 2'h1,
    DRV_CML   = 2'h2,
    DRV_ECL   = 2'h3
  } drv_type_t;

  // Per-channel view handed to the analog drivers.
  typedef struct packed
  {
    logic       clk_out;
    logic       drive_en;
    drv_type_t  drv_type;
  } chan_out_t;

  // Register read and write request from the configuration port.
  typedef struct packed
  {
    logic        wr_en;
    logic        rd_en;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage

// *** hdl/output_channel_config_bank.sv ***
// Configuration bank and output stage for the four integer-divided clock channels.
`timescale 1ns/100ps
// Function
// RULE1 - Host writes zero into reserved bits.
// RULE2 - Output state: off, run, static low, static high.
// RULE3 - Driver type: LVDS, LVDS, CML, ECL.
// RULE4 - Pair AB divider ratio is value plus one.
// RULE5 - Pair CD divider ratio is value plus one.
// RULE6 - Bit 0 selects pair supply level.
// RULE7 - Lower channel bits 4:1, upper 8:5.
// RULE8 - Sync bit low holds dividers aligned.
// RULE9 - Run bit low holds device, keeps registers.
module output_channel_config_bank
(
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire outbank_pkg::reg_req_t  req_i,
  input  wire logic                   divider_sync_release_i,
  input  wire logic                   device_run_not_held_i,
  output outbank_pkg::chan_out_t      chan_a_o,
  output outbank_pkg::chan_out_t      chan_b_o,
  output outbank_pkg::chan_out_t      chan_c_o,
  output outbank_pkg::chan_out_t      chan_d_o,
  output logic                        pair_ab_supply_select_o,
  output logic                        pair_cd_supply_select_o,
  output logic [15:0]                 rdata_o,
  output logic                        rvalid_o
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [8:0]  ab_ctrl_r;
  logic [8:0]  ab_ctrl_nxt;
  logic [8:0]  cd_ctrl_r;
  logic [8:0]  cd_ctrl_nxt;
  logic [7:0]  pair_ab_integer_divider_r;
  logic [7:0]  ab_div_nxt;
  logic [7:0]  pair_cd_integer_divider_r;
  logic [7:0]  cd_div_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;

  // Reserved bits are not stored, so a stray nonzero write cannot steer anything.
  always_comb
  begin
    ab_ctrl_nxt = ab_ctrl_r;
    cd_ctrl_nxt = cd_ctrl_r;
    ab_div_nxt  = pair_ab_integer_divider_r;
    cd_div_nxt  = pair_cd_integer_divider_r;
    if (req_i.wr_en)
    begin
      unique case (req_i.addr)
        outbank_pkg::OFS_PAIR_AB_CTRL: ab_ctrl_nxt = req_i.wdata[8:0]; // RULE1
        outbank_pkg::OFS_PAIR_CD_CTRL: cd_ctrl_nxt = req_i.wdata[8:0];
        outbank_pkg::OFS_PAIR_AB_DIV:  ab_div_nxt  = req_i.wdata[7:0]; // RULE4
        outbank_pkg::OFS_PAIR_CD_DIV:  cd_div_nxt  = req_i.wdata[7:0]; // RULE5
        default: ;
      endcase
    end
  end

  // Readback; reserved bits read zero and unmapped offsets return zero.
  always_comb
  begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = req_i.rd_en;
    if (req_i.rd_en)
    begin
      unique case (req_i.addr)
        outbank_pkg::OFS_PAIR_AB_CTRL: rdata_nxt = {7'h00, ab_ctrl_r};
        outbank_pkg::OFS_PAIR_CD_CTRL: rdata_nxt = {7'h00, cd_ctrl_r};
        outbank_pkg::OFS_PAIR_AB_DIV:  rdata_nxt = {8'h00, pair_ab_integer_divider_r};
        outbank_pkg::OFS_PAIR_CD_DIV:  rdata_nxt = {8'h00, pair_cd_integer_divider_r};
        default:                       rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Register contents survive the run-hold; only the pin reset clears them.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ab_ctrl_r                 <= outbank_pkg::CTRL_RESET;
      cd_ctrl_r                 <= outbank_pkg::CTRL_RESET;
      pair_ab_integer_divider_r <= outbank_pkg::DIV_RESET;
      pair_cd_integer_divider_r <= outbank_pkg::DIV_RESET;
      rdata_r                   <= 16'h0000;
      rvalid_r                  <= 1'b0;
    end
    else
    begin
      ab_ctrl_r                 <= ab_ctrl_nxt; // RULE9
      cd_ctrl_r                 <= cd_ctrl_nxt;
      pair_ab_integer_divider_r <= ab_div_nxt;
      pair_cd_integer_divider_r <= cd_div_nxt;
      rdata_r                   <= rdata_nxt;
      rvalid_r                  <= rvalid_nxt;
    end
  end

  // ****************************************************************
  // Field decode.
  // ****************************************************************
  outbank_pkg::out_state_t chan_a_output_state;
  outbank_pkg::out_state_t chan_b_output_state;
  outbank_pkg::out_state_t chan_c_output_state;
  outbank_pkg::out_state_t chan_d_output_state;
  outbank_pkg::drv_type_t  chan_a_driver_type;
  outbank_pkg::drv_type_t  chan_b_driver_type;
  outbank_pkg::drv_type_t  chan_c_driver_type;
  outbank_pkg::drv_type_t  chan_d_driver_type;

  // Lower channel sits in bits 4:1, upper in bits 8:5 of each pair register.
  assign chan_a_output_state = outbank_pkg::out_state_t'(ab_ctrl_r[outbank_pkg::POS_LO_STATE +: 2]); // RULE7
  assign chan_a_driver_type  = outbank_pkg::drv_type_t'(ab_ctrl_r[outbank_pkg::POS_LO_DRV +: 2]);
  assign chan_b_output_state = outbank_pkg::out_state_t'(ab_ctrl_r[outbank_pkg::POS_HI_STATE +: 2]);
  assign chan_b_driver_type  = outbank_pkg::drv_type_t'(ab_ctrl_r[outbank_pkg::POS_HI_DRV +: 2]);
  assign chan_c_output_state = outbank_pkg::out_state_t'(cd_ctrl_r[outbank_pkg::POS_LO_STATE +: 2]);
  assign chan_c_driver_type  = outbank_pkg::drv_type_t'(cd_ctrl_r[outbank_pkg::POS_LO_DRV +: 2]);
  assign chan_d_output_state = outbank_pkg::out_state_t'(cd_ctrl_r[outbank_pkg::POS_HI_STATE +: 2]);
  assign chan_d_driver_type  = outbank_pkg::drv_type_t'(cd_ctrl_r[outbank_pkg::POS_HI_DRV +: 2]);

  // ****************************************************************
  // Shared dividers.
  // ****************************************************************
  logic div_hold;
  logic ab_clk;
  logic cd_clk;

  // Both dividers are held at their start point while sync is forced or the device is held.
  assign div_hold = !divider_sync_release_i || !device_run_not_held_i; // RULE8 RULE9

  pair_divider #(.DIV_W(outbank_pkg::DIV_BITS)) u_div_ab
  (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .hold_i     (div_hold),
    .ratio_m1_i (pair_ab_integer_divider_r),
    .clk_en_o   (),
    .div_clk_o  (ab_clk)
  );

  pair_divider #(.DIV_W(outbank_pkg::DIV_BITS)) u_div_cd
  (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .hold_i     (div_hold),
    .ratio_m1_i (pair_cd_integer_divider_r),
    .clk_en_o   (),
    .div_clk_o  (cd_clk)
  );

  // Output state decode for one channel; a held device drives nothing.
  function automatic outbank_pkg::chan_out_t shape(input outbank_pkg::out_state_t st,
                                                   input outbank_pkg::drv_type_t dt,
                                                   input logic clk, input logic run);
    outbank_pkg::chan_out_t o;
    o.drv_type = dt; // RULE3
    o.drive_en = run && (st != outbank_pkg::ST_OFF); // RULE2
    unique case (st)
      outbank_pkg::ST_OFF:  o.clk_out = 1'b0;
      outbank_pkg::ST_RUN:  o.clk_out = clk;
      outbank_pkg::ST_LOW:  o.clk_out = 1'b0;
      outbank_pkg::ST_HIGH: o.clk_out = 1'b1;
    endcase
    if (!run)
    begin
      o.clk_out = 1'b0;
    end
    return o;
  endfunction

  // ****************************************************************
  // Registered outputs.
  // ****************************************************************
  outbank_pkg::chan_out_t a_nxt;
  outbank_pkg::chan_out_t b_nxt;
  outbank_pkg::chan_out_t c_nxt;
  outbank_pkg::chan_out_t d_nxt;

  // Channel shaping for all four outputs.
  always_comb
  begin
    a_nxt = shape(chan_a_output_state, chan_a_driver_type, ab_clk, device_run_not_held_i);
    b_nxt = shape(chan_b_output_state, chan_b_driver_type, ab_clk, device_run_not_held_i);
    c_nxt = shape(chan_c_output_state, chan_c_driver_type, cd_clk, device_run_not_held_i);
    d_nxt = shape(chan_d_output_state, chan_d_driver_type, cd_clk, device_run_not_held_i);
  end

  // Output flops keep every top-level output glitch free.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      chan_a_o                <= '0;
      chan_b_o                <= '0;
      chan_c_o                <= '0;
      chan_d_o                <= '0;
      pair_ab_supply_select_o <= 1'b0;
      pair_cd_supply_select_o <= 1'b0;
    end
    else
    begin
      chan_a_o                <= a_nxt;
      chan_b_o                <= b_nxt;
      chan_c_o                <= c_nxt;
      chan_d_o                <= d_nxt;
      pair_ab_supply_select_o <= ab_ctrl_r[outbank_pkg::POS_SUPPLY]; // RULE6
      pair_cd_supply_select_o <= cd_ctrl_r[outbank_pkg::POS_SUPPLY];
    end
  end

  assign rdata_o  = rdata_r;
  assign rvalid_o = rvalid_r;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_static_high_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE2
    (chan_a_output_state == outbank_pkg::ST_HIGH && device_run_not_held_i)
      |=> (chan_a_o.clk_out && chan_a_o.drive_en))
    else $error("channel a static high not driven");

  a_off_no_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE2
    (chan_c_output_state == outbank_pkg::ST_OFF) |=> !chan_c_o.drive_en)
    else $error("channel c drives while off");

  a_drv_type_copy: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE3
    ##1 chan_d_o.drv_type == $past(chan_d_driver_type))
    else $error("channel d driver type mismatch");

  a_ab_div_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    (req_i.wr_en && req_i.addr == outbank_pkg::OFS_PAIR_AB_DIV)
      |=> pair_ab_integer_divider_r == $past(req_i.wdata[7:0]))
    else $error("pair ab divider not stored");

  a_cd_div_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE5
    (req_i.rd_en && req_i.addr == outbank_pkg::OFS_PAIR_CD_DIV && !req_i.wr_en)
      |=> rvalid_o && rdata_o == {8'h00, pair_cd_integer_divider_r})
    else $error("pair cd divider readback wrong");

  a_supply_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE6
    $changed(ab_ctrl_r[0]) |=> pair_ab_supply_select_o == $past(ab_ctrl_r[0]))
    else $error("pair ab supply select lagging");

  a_hi_field_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
    (req_i.wr_en && req_i.addr == outbank_pkg::OFS_PAIR_CD_CTRL)
      |=> chan_d_output_state == outbank_pkg::out_state_t'($past(req_i.wdata[6:5])))
    else $error("channel d state field misplaced");

  a_sync_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE8
    (!divider_sync_release_i)[*2] |-> !ab_clk && !cd_clk)
    else $error("dividers toggle while synchronised");

  a_run_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
    !device_run_not_held_i |=> !chan_b_o.drive_en && !chan_b_o.clk_out)
    else $error("channel b active while device held");

endmodule

// *** hdl/pair_divider.sv ***
// Shared integer divider for one channel pair with synchronous hold.
`timescale 1ns/100ps
module pair_divider
#(
  parameter int DIV_W = 8
)
(
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             hold_i,
  input  wire logic [DIV_W-1:0] ratio_m1_i,
  output logic                  clk_en_o,
  output logic                  div_clk_o
);

  // Widths past sixteen bits are refused at elaboration, because nothing needs such long reload paths.
  if (DIV_W < 1 || DIV_W > 16)
  begin
    $error("pair_divider: DIV_W out of range");
  end

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic             tgl_r;
  logic             tgl_nxt;
  logic             en_r;
  logic             en_nxt;

  // Count down from the stored value; each wrap marks one half period of value plus one cycles.
  always_comb
  begin
    cnt_nxt = cnt_r;
    tgl_nxt = tgl_r;
    en_nxt  = 1'b0;
    if (hold_i)
    begin
      cnt_nxt = ratio_m1_i;
      tgl_nxt = 1'b0;
    end
    else if (cnt_r == '0)
    begin
      cnt_nxt = ratio_m1_i;
      tgl_nxt = ~tgl_r;
      en_nxt  = 1'b1;
    end
    else
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Registering stage.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= '0;
      tgl_r <= 1'b0;
      en_r  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tgl_r <= tgl_nxt;
      en_r  <= en_nxt;
    end
  end

  assign clk_en_o  = en_r;
  assign div_clk_o = tgl_r;

endmodule
